// ---- tb/rxwb_host_mem.sv ----
// Host memory model: sixteen descriptor status words shared with the engine.
// Assumes one word per request; each answer comes after memLat waiting cycles.
`default_nettype none
module rxwb_host_mem (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata,
    input wire logic [3:0] memLat
);
    logic [31:0] mem [0:15]; // Status words
    logic [31:0] rdBuf = 32'h0; // Word carried by the last read answer
    logic [3:0] wait_r = 4'h0; // Cycles waited on the current request
    int badWrites = 0; // Writes to driver-owned words
    initial memAck = 1'b0;
    // Answer after memLat waits
    always @(posedge core_clk) begin
        memAck <= 1'b0;
        if (rst) begin
            wait_r <= 4'h0;
        end else if (memReq && !memAck) begin
            if (wait_r < memLat) begin
                wait_r <= wait_r + 4'h1;
            end else begin
                wait_r <= 4'h0;
                memAck <= 1'b1;
                if (memWrite) begin
                    if (!mem[memAddr[5:2]][31]) badWrites++;
                    mem[memAddr[5:2]] <= memWdata;
                end else begin
                    rdBuf <= mem[memAddr[5:2]];
                end
            end
        end
    end
    // Outside an answer the read lines carry no stale word
    assign memRdata = memAck ? rdBuf : ~rdBuf;
endmodule // rxwb_host_mem
`default_nettype wire

// ---- tb/rxwb_monitor.sv ----
// Checker of the engine's claim verdicts and status writes.
// Assumes it is bound to rxwb_writeback and sees that module's ports only.
`default_nettype none
module rxwb_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic descGranted,
    input wire logic descRefused,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memAck,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    input wire logic [31:0] memRdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire wr = memReq && memWrite; // Status write on offer
    wire fl = wr && (memWdata[9] || memWdata[8]); // Write to a first or last descriptor
    wire [31:0] w = memWdata; // Short alias for the written word
    // Descriptor read answered
    sequence s_own; memReq && !memWrite && memAck && memRdata[31]; endsequence
    sequence s_free; memReq && !memWrite && memAck && !memRdata[31]; endsequence
    property p_grant; s_own |-> ##[1:8] descGranted; endproperty
    a_grant: assert property (p_grant) else $error("no grant after owned read");
    property p_refuse; s_free |-> ##[1:8] descRefused; endproperty
    a_refuse: assert property (p_refuse) else $error("no refusal after free read");
    property p_excl; descGranted |-> !descRefused; endproperty
    a_excl: assert property (p_excl) else $error("grant and refusal together");
    property p_release; wr |-> !w[31]; endproperty
    a_release: assert property (p_release) else $error("write keeps owner high");
    // Done rides in the releasing word
    property p_done; fl |-> w[30] && !w[31]; endproperty
    a_done: assert property (p_done) else $error("end word without done");
    property p_mid; wr && !fl |-> w == 32'h00000000; endproperty
    a_mid: assert property (p_mid) else $error("middle word not blank");
    property p_err; fl |-> w[15] == (w[1] || w[6] || w[7] || w[11]); endproperty
    a_err: assert property (p_err) else $error("error summary wrong");
    property p_short; fl |-> w[11] == (w[29:16] < 14'h0040); endproperty
    a_short: assert property (p_short) else $error("short flag wrong");
    property p_type; fl |-> w[13:12] != 2'h3; endproperty
    a_type: assert property (p_type) else $error("reserved frame type");
    // Request held until answered
    property p_hold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(w) && $stable(memWrite);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed early");
endmodule // rxwb_monitor
bind rxwb_writeback rxwb_monitor rxwb_monitor_i (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the receive status write-back engine.
// Assumes the host memory model and the bound checker are compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, descNeed = 1'b0, bufFull = 1'b0, frameEnd = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, descAddr = 32'h0;
    logic [3:0] wstrb = 4'hF, memLat = 4'h0; // Full-word writes only
    logic [13:0] frameLen = 14'h0;
    logic crcErr = 1'b0, lateEvent = 1'b0, tooLong = 1'b0, multicast = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, irq, descGranted, descBusy, descRefused;
    wire memReq, memWrite, memAck;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, memAddr, memWdata, memRdata;
    int n_fail = 0, comparisons = 0, frames = 0;
    rxwb_writeback rxwb_writeback_i (.*);
    rxwb_host_mem rxwb_host_mem_i (.*);
    initial forever #5 core_clk = ~core_clk;
    task automatic end_sim;
        $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        n_fail++;
        $display("Error at %0t: timeout in %s", $time, what);
        end_sim;
    endtask
    // Register write, each half dropped once taken
    task automatic axiW(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask
    // Register read and compare
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        int n;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk(rdata, exp, what);
                chk(rresp, (a > 8'h10) ? 32'h2 : 32'h0, "read response");
                return;
            end
        end
        hang("read");
    endtask
    // Ask for descriptor i and compare the verdict
    task automatic claim(input int i, input logic expGrant);
        int n;
        @(posedge core_clk);
        descAddr <= 32'h00001000 + 32'(i * 4);
        descNeed <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge core_clk);
            if (descGranted || descRefused) begin
                descNeed <= 1'b0;
                chk(descGranted, expGrant, "claim verdict");
                return;
            end
        end
        hang("claim");
    endtask
    // One-cycle pulse on frame end or on buffer full
    task automatic pulse(input logic fe);
        @(posedge core_clk);
        if (fe) frameEnd <= 1'b1; else bufFull <= 1'b1;
        @(posedge core_clk);
        frameEnd <= 1'b0;
        bufFull <= 1'b0;
    endtask
    // Wait until the engine is idle
    task automatic idle;
        int n;
        repeat (3) @(posedge core_clk);
        for (n = 0; n < 200; n++) begin
            if (!descBusy && !memReq) return;
            @(posedge core_clk);
        end
        hang("idle");
    endtask
    // Expected end word; e = {mcast, long, late, crc}
    function automatic logic [31:0] expW(logic [13:0] len, logic [3:0] e, logic [1:0] lb, logic f, logic l);
        logic s;
        s = len < 14'h0040;
        expW = {2'b01, len, (|e[2:0]) | s, 1'b0, (lb == 2'h3) ? 2'h0 : lb, s, e[3], f, l, e[2], e[1], 4'h0,
            e[0], 1'b0};
    endfunction
    // Frame over n descriptors, words compared
    task automatic frame(input int n, input logic [13:0] len, input logic [3:0] e, input logic [1:0] lb);
        logic [1:0] r;
        int i;
        axiW(8'h00, {20'h0, lb, 10'h0}, r);
        for (i = 0; i < n; i++) rxwb_host_mem_i.mem[i] <= 32'h80000000;
        for (i = 0; i < n; i++) begin
            claim(i, 1'b1);
            if (i < n - 1) pulse(1'b0);
        end
        frameLen <= len;
        {multicast, tooLong, lateEvent, crcErr} <= e;
        pulse(1'b1);
        idle;
        frames++;
        chk(rxwb_host_mem_i.mem[0], expW(len, e, lb, 1'b1, n == 1), "first word");
        for (i = 1; i < n - 1; i++) chk(rxwb_host_mem_i.mem[i], 32'h0, "middle word");
        if (n > 1) chk(rxwb_host_mem_i.mem[n - 1], expW(len, e, lb, 1'b0, 1'b1), "last word");
        rdChk(8'h0C, expW(len, e, lb, n == 1, 1'b1), "last status");
        chk(rxwb_host_mem_i.badWrites, 32'h0, "owner");
    endtask
    // Reset values and unmapped places
    task automatic tRegs;
        logic [1:0] r;
        rdChk(8'h00, 32'h0, "ctrl reset");
        rdChk(8'h04, 32'h0, "status reset");
        rdChk(8'h08, 32'h0, "mask reset");
        rdChk(8'h40, 32'h0, "unmapped read");
        axiW(8'h40, 32'hFFFFFFFF, r);
        chk(r, 32'h2, "unmapped write");
    endtask
    // Frame types, runt edge, errors, split frames
    task automatic tFrames;
        logic [13:0] lens [4] = '{14'h003F, 14'h0040, 14'h05EE, 14'h0041};
        logic [3:0] errs [4] = '{4'h0, 4'h1, 4'hA, 4'h4};
        int k;
        for (k = 0; k < 4; k++) frame(1, lens[k], errs[k], 2'(k));
        memLat <= 4'h5;
        frame(2, 14'h0200, 4'h2, 2'h2);
        frame(4, 14'h0100, 4'h0, 2'h1);
        memLat <= 4'h0;
    endtask
    // Interrupts and a refused descriptor
    task automatic tIrq;
        logic [1:0] r;
        axiW(8'h04, 32'h7, r);
        axiW(8'h08, 32'h7, r);
        frame(1, 14'h0030, 4'h0, 2'h0);
        rdChk(8'h04, 32'h3, "events");
        chk(irq, 32'h1, "irq raised");
        axiW(8'h08, 32'h0, r);
        repeat (2) @(posedge core_clk);
        chk(irq, 32'h0, "irq masked");
        axiW(8'h04, 32'h3, r);
        rdChk(8'h04, 32'h0, "events cleared");
        rxwb_host_mem_i.mem[8] <= 32'h12345678;
        axiW(8'h08, 32'h4, r);
        claim(8, 1'b0);
        idle;
        chk(rxwb_host_mem_i.mem[8], 32'h12345678, "refused word");
        rdChk(8'h04, 32'h4, "refusal event");
        chk(irq, 32'h1, "irq on refusal");
        axiW(8'h04, 32'h4, r);
        repeat (2) @(posedge core_clk);
        chk(irq, 32'h0, "irq cleared");
        rdChk(8'h10, 32'(frames), "frame count");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        tRegs;
        tFrames;
        tIrq;
        end_sim;
    end
endmodule // testbench
`default_nettype wire

// ---- verilog/rxwb_axil_slave.v ----
// AXI4-Lite slave: control, W1C events, mask, last status, frame count.
// Assumes one write and one read outstanding at most, as AXI4-Lite masters keep.
`include "rxwb_regs.vh"
`default_nettype none
module rxwb_axil_slave (
    input wire core_clk,
    input wire rst,
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire [2:0] evPulse,
    input wire [31:0] lastStatus,
    input wire [15:0] frameCount,
    output reg [31:0] ctrl_r,
    output reg irq
);
    reg [7:0] awAddr_r;
    reg awHave_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg wHave_r;
    reg [2:0] stat_r;
    reg [2:0] mask_r;
    wire doWrite;
    wire [2:0] w1c;
    wire [31:0] ctrl_nxt;
    integer i;

    // A write happens once both halves are held and no response is pending
    assign doWrite = awHave_r && wHave_r && !bvalid;
    assign w1c = (doWrite && awAddr_r == `RXWB_ADDR_STAT && wStrb_r[0]) ? wData_r[2:0] : 3'h0;

    // Byte-lane merge for the control register
    function [31:0] laneMerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            laneMerge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    laneMerge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction
    assign ctrl_nxt = laneMerge(ctrl_r, wData_r, wStrb_r);

    // Write channel: take address and data in either order, then answer
    always @(posedge core_clk) begin
        if (rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RXWB_RESP_OK;
            ctrl_r <= `RXWB_CTRL_RST;
            mask_r <= `RXWB_MASK_RST;
        end else begin
            awready <= !awHave_r && !awready && awvalid;
            wready <= !wHave_r && !wready && wvalid;
            if (awvalid && awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHave_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (doWrite) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `RXWB_RESP_OK;
                case (awAddr_r)
                    `RXWB_ADDR_CTRL: ctrl_r <= ctrl_nxt;
                    `RXWB_ADDR_MASK: begin
                        if (wStrb_r[0]) begin
                            mask_r <= wData_r[2:0];
                        end
                    end
                    `RXWB_ADDR_STAT, `RXWB_ADDR_LAST, `RXWB_ADDR_COUNT: bresp <= `RXWB_RESP_OK;
                    default: bresp <= `RXWB_RESP_SLVERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always @(posedge core_clk) begin
        if (rst) begin
            stat_r <= 3'h0;
            irq <= 1'b0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                stat_r[i] <= evPulse[i] | (stat_r[i] & ~w1c[i]);
            end
            irq <= |((evPulse | (stat_r & ~w1c)) & mask_r);
        end
    end

    // Read channel: one cycle to accept, data registered next
    always @(posedge core_clk) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RXWB_RESP_OK;
        end else begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `RXWB_RESP_OK;
                case (araddr)
                    `RXWB_ADDR_CTRL: rdata <= ctrl_r;
                    `RXWB_ADDR_STAT: rdata <= {29'h0, stat_r};
                    `RXWB_ADDR_MASK: rdata <= {29'h0, mask_r};
                    `RXWB_ADDR_LAST: rdata <= lastStatus;
                    `RXWB_ADDR_COUNT: rdata <= {16'h0, frameCount};
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `RXWB_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // rxwb_axil_slave
`default_nettype wire

// ---- verilog/rxwb_desc_mem.v ----
// Descriptor-address memory for the frame in progress; registered read.
// Assumes one clock; the caller never reads and writes the same slot at once.
`default_nettype none
module rxwb_desc_mem (
    input wire core_clk,
    input wire wrEn,
    input wire [3:0] wrAddr,
    input wire [31:0] wrData,
    input wire [3:0] rdAddr,
    output reg [31:0] rdData
);
    // Sixteen slots: the most descriptors one frame may span here
    reg [31:0] slot [0:15];

    // Write port, and read data taken from a register
    always @(posedge core_clk) begin
        if (wrEn) begin
            slot[wrAddr] <= wrData;
        end
        rdData <= slot[rdAddr];
    end
endmodule // rxwb_desc_mem
`default_nettype wire

// ---- verilog/rxwb_regs.vh ----
// Constants of the status write-back block: word layout, bus offsets, resets.
// Assumes inclusion by bare name from the design files only.
`ifndef RXWB_REGS_VH
`define RXWB_REGS_VH
// Status word field positions
`define RXWB_OWN_BIT 31
`define RXWB_DONE_BIT 30
`define RXWB_LEN_HI 29
`define RXWB_LEN_LO 16
`define RXWB_ERRSUM_BIT 15
`define RXWB_TYPE_HI 13
`define RXWB_TYPE_LO 12
`define RXWB_SHORT_BIT 11
`define RXWB_MCAST_BIT 10
`define RXWB_FIRST_BIT 9
`define RXWB_LAST_BIT 8
`define RXWB_LONG_BIT 7
`define RXWB_LATE_BIT 6
`define RXWB_CRC_BIT 1
// Frame-type encodings
`define RXWB_TYPE_NORMAL 2'h0
`define RXWB_TYPE_INTLOOP 2'h1
`define RXWB_TYPE_EXTLOOP 2'h2
`define RXWB_TYPE_RSVD 2'h3
// Runt threshold in bytes
`define RXWB_MIN_FRAME 14'h0040
// Register offsets (byte addresses)
`define RXWB_ADDR_CTRL 8'h00
`define RXWB_ADDR_STAT 8'h04
`define RXWB_ADDR_MASK 8'h08
`define RXWB_ADDR_LAST 8'h0C
`define RXWB_ADDR_COUNT 8'h10
// Event bit positions in status and mask
`define RXWB_EV_FRAME 0
`define RXWB_EV_ERROR 1
`define RXWB_EV_NODESC 2
// Reset values
`define RXWB_CTRL_RST 32'h00000000
`define RXWB_MASK_RST 3'h0
// Bus responses
`define RXWB_RESP_OK 2'h0
`define RXWB_RESP_SLVERR 2'h2
`endif

// ---- verilog/rxwb_writeback.v ----
// Receive status write-back engine: claims, releases and finalises descriptors.
// Assumes a one-word memory master and a receive path with frame-end flags.
// Notes on behaviour
// - Touch descriptor only while owner flag high.
// - Owner flag honoured on every frame descriptor.
// - Set done flag in first and last.
// - Done flag meaningful only in first/last.
// - Length field counts bytes including CRC.
// - Error summary ORs CRC, late, long, short.
// - Frame type copies control loopback bits.
// - Types 00 normal, 01 internal, 10 external.
// - Short flag set below 64 bytes.
// - Full status into first and last descriptors.
// - Clear owner flag once buffer fills; the first descriptor keeps it until frame end.
// - Mark first/last segment flags per descriptor.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`include "rxwb_regs.vh"
`default_nettype none
module rxwb_writeback (
    input wire core_clk,
    input wire rst,
    // Register bus
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    output wire irq,
    // Receive path
    input wire descNeed,
    input wire [31:0] descAddr,
    input wire bufFull,
    input wire frameEnd,
    input wire [13:0] frameLen,
    input wire crcErr,
    input wire lateEvent,
    input wire tooLong,
    input wire multicast,
    output reg descGranted,
    output reg descBusy,
    output reg descRefused,
    // Host memory master, one status word per request
    output reg memReq,
    output reg memWrite,
    output reg [31:0] memAddr,
    output reg [31:0] memWdata,
    input wire memAck,
    input wire [31:0] memRdata
);
    // States, one-hot
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_FETCH = 6'h02;
    localparam [5:0] S_HOLD = 6'h04;
    localparam [5:0] S_REL = 6'h08;
    localparam [5:0] S_FIN = 6'h10;
    localparam [5:0] S_WAIT = 6'h20;

    reg [5:0] state_r;
    reg [3:0] descCnt_r;     // Descriptors taken for this frame
    reg [3:0] finIdx_r;      // Slot being finalised
    reg [31:0] finalWord_r;  // Status for first/last descriptors
    reg [31:0] lastStatus_r; // Last status written, visible to software
    reg [15:0] frameCount_r; // Frames completed
    reg [2:0] evPulse_r;     // Frame done, frame error, descriptor refused
    reg memWriteCur_r;
    wire [31:0] ctrl;
    wire [31:0] memSlotData;
    wire [1:0] loopBits;
    wire frameErr;
    wire isShort;
    wire [3:0] rdSel;

    // Control bits 11:10 are the loopback mode of the network control register
    assign loopBits = ctrl[11:10];
    assign isShort = frameLen < `RXWB_MIN_FRAME;
    assign frameErr = crcErr | lateEvent | tooLong | isShort;
    assign rdSel = finIdx_r;

    // Type code: reserved pattern is never produced, falls back to normal
    function [1:0] typeCode;
        input [1:0] lb;
        begin
            case (lb)
                `RXWB_TYPE_INTLOOP: typeCode = `RXWB_TYPE_INTLOOP;
                `RXWB_TYPE_EXTLOOP: typeCode = `RXWB_TYPE_EXTLOOP;
                default: typeCode = `RXWB_TYPE_NORMAL;
            endcase
        end
    endfunction

    // Segment word: owner cleared, first/last marks, status fields optional
    function [31:0] segWord;
        input first;
        input last;
        input [31:0] full;
        begin
            segWord = 32'h00000000;
            if (first || last) begin
                segWord = full;
            end
            segWord[`RXWB_OWN_BIT] = 1'b0;
            segWord[`RXWB_FIRST_BIT] = first;
            segWord[`RXWB_LAST_BIT] = last;
        end
    endfunction

    rxwb_axil_slave uBus (
        .core_clk(core_clk),
        .rst(rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .evPulse(evPulse_r),
        .lastStatus(lastStatus_r),
        .frameCount(frameCount_r),
        .ctrl_r(ctrl),
        .irq(irq)
    );

    // Addresses of all descriptors in the frame, replayed for the first and last
    rxwb_desc_mem uMem (
        .core_clk(core_clk),
        .wrEn(state_r == S_FETCH && memAck && memRdata[`RXWB_OWN_BIT]),
        .wrAddr(descCnt_r),
        .wrData(memAddr),
        .rdAddr(rdSel),
        .rdData(memSlotData)
    );

    // Main sequencer
    always @(posedge core_clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            descCnt_r <= 4'h0;
            finIdx_r <= 4'h0;
            finalWord_r <= 32'h00000000;
            lastStatus_r <= 32'h00000000;
            frameCount_r <= 16'h0000;
            evPulse_r <= 3'h0;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= 32'h00000000;
            memWdata <= 32'h00000000;
            memWriteCur_r <= 1'b0;
            descGranted <= 1'b0;
            descBusy <= 1'b0;
            descRefused <= 1'b0;
        end else begin
            evPulse_r <= 3'h0;
            descGranted <= 1'b0;
            descRefused <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    // Read the owner flag before touching a descriptor
                    if (descNeed) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b0;
                        memAddr <= descAddr;
                        descBusy <= 1'b1;
                        state_r <= S_FETCH;
                    end else if (frameEnd && descCnt_r != 4'h0) begin
                        state_r <= S_FIN;
                    end else begin
                        descBusy <= 1'b0;
                    end
                end
                S_FETCH: begin
                    if (memAck) begin
                        memReq <= 1'b0;
                        if (memRdata[`RXWB_OWN_BIT]) begin
                            descGranted <= 1'b1;
                            descCnt_r <= descCnt_r + 4'h1;
                            state_r <= S_HOLD;
                        end else begin
                            // Driver still owns it: leave it untouched
                            descRefused <= 1'b1;
                            evPulse_r[`RXWB_EV_NODESC] <= 1'b1;
                            descBusy <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_HOLD: begin
                    // Intermediate buffer filled: hand it back at once
                    if (bufFull && !frameEnd && descCnt_r != 4'h1) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memWdata <= segWord(1'b0, 1'b0, 32'h0);
                        state_r <= S_REL;
                    end else if (frameEnd) begin
                        state_r <= S_FIN;
                    end else if (bufFull) begin
                        // First descriptor is held back until frame end
                        descBusy <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_REL: begin
                    if (memAck) begin
                        memReq <= 1'b0;
                        memWrite <= 1'b0;
                        descBusy <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FIN: begin
                    // Build the full status for each end word, first then last; owner clear goes out in the same word
                    finalWord_r <= {1'b0, 1'b1, frameLen, frameErr, 1'b0, typeCode(loopBits), isShort,
                        multicast, 2'h0, tooLong, lateEvent, 4'h0, crcErr, 1'b0};
                    descBusy <= 1'b1;
                    state_r <= S_WAIT;
                    memWriteCur_r <= 1'b0;
                end
                S_WAIT: begin
                    if (!memWriteCur_r) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memAddr <= memSlotData;
                        memWdata <= segWord(finIdx_r == 4'h0, finIdx_r == descCnt_r - 4'h1,
                            finalWord_r);
                        memWriteCur_r <= 1'b1;
                    end else if (memAck) begin
                        memReq <= 1'b0;
                        memWrite <= 1'b0;
                        memWriteCur_r <= 1'b0;
                        if (finIdx_r == descCnt_r - 4'h1) begin
                            lastStatus_r <= memWdata;
                            frameCount_r <= frameCount_r + 16'h0001;
                            evPulse_r[`RXWB_EV_FRAME] <= 1'b1;
                            evPulse_r[`RXWB_EV_ERROR] <= finalWord_r[`RXWB_ERRSUM_BIT];
                            descCnt_r <= 4'h0;
                            finIdx_r <= 4'h0;
                            descBusy <= 1'b0;
                            state_r <= S_IDLE;
                        end else begin
                            // Then the last slot
                            finIdx_r <= descCnt_r - 4'h1;
                            state_r <= S_FIN;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // rxwb_writeback
`default_nettype wire
